/* pkg/dlsc_defs.vh */
// register offsets, field positions, reset values and timing counts
// assumes a 25 MHz core clock
`ifndef DLSC_DEFS_VH
`define DLSC_DEFS_VH

`define DLSC_ADDR_DARK_MAX    8'h0d
`define DLSC_ADDR_DARK_DIM    8'h0e
`define DLSC_ADDR_FADE_LAW    8'h0f
`define DLSC_ADDR_SINK_EN     8'h10
`define DLSC_ADDR_SINK_TIME1  8'h11

`define DLSC_CODE_MSB         6
`define DLSC_LAW_MSB          1
`define DLSC_RST_BYTE         8'h00

`define DLSC_LAW_LIN          2'h0
`define DLSC_LAW_SQR          2'h1
`define DLSC_LAW_CUBIC_A      2'h2
`define DLSC_LAW_CUBIC_B      2'h3

// timing base: 0.2 s tick, times are whole multiples of it
`define DLSC_CLK_HZ           25000000
`define DLSC_TICK_MS          200
`define DLSC_TICK_CYC         ((`DLSC_CLK_HZ / 1000) * `DLSC_TICK_MS)
// last count of the tick divider, sized to its 24-bit counter
`define DLSC_TICK_LAST        24'h4c4b3f

// on times in ticks: 0.2, 0.6, 0.8, 1.2 s
`define DLSC_ON_T0            4'h1
`define DLSC_ON_T1            4'h3
`define DLSC_ON_T2            4'h4
`define DLSC_ON_T3            4'h6
// off times in ticks: 0.6, 1.2, 1.8 s
`define DLSC_OFF_T1           4'h3
`define DLSC_OFF_T2           4'h6
`define DLSC_OFF_T3           4'h9

`endif

/* core/dlsc_blink.v */
// one blink sequencer for a single sink
// assumes a shared one-cycle tick every 0.2 s and synchronous inputs
`timescale 1ns/10ps
`include "dlsc_defs.vh"

module dlsc_blink (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       tick,
  input  wire       start,
  input  wire       enable,
  input  wire [1:0] on_sel,
  input  wire [1:0] off_sel,
  output reg        sink_on_q
);

  reg [3:0] cnt_q;
  reg [3:0] on_len;
  reg [3:0] off_len;

  always @* begin
    case (on_sel)
      2'h0:    on_len = `DLSC_ON_T0;
      2'h1:    on_len = `DLSC_ON_T1;
      2'h2:    on_len = `DLSC_ON_T2;
      default: on_len = `DLSC_ON_T3;
    endcase
    case (off_sel)
      2'h1:    off_len = `DLSC_OFF_T1;
      2'h2:    off_len = `DLSC_OFF_T2;
      default: off_len = `DLSC_OFF_T3;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sink_on_q <= 1'b0;
      cnt_q     <= 4'h0;
    end else if (!enable) begin
      sink_on_q <= 1'b0;
      cnt_q     <= 4'h0;
    end else if (start) begin
      sink_on_q <= 1'b1;
      cnt_q     <= 4'h0;
    end else if (off_sel == 2'h0) begin
      sink_on_q <= 1'b1;
      cnt_q     <= 4'h0;
    end else if (tick) begin
      if (sink_on_q && (cnt_q + 4'h1 >= on_len)) begin
        sink_on_q <= 1'b0;
        cnt_q     <= 4'h0;
      end else if (!sink_on_q && (cnt_q + 4'h1 >= off_len)) begin
        sink_on_q <= 1'b1;
        cnt_q     <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

endmodule

/* core/dlsc_regs.v */
// register slice: dark-level currents, sink fade law, sink enables, first timing register
// assumes a byte-wide register write/read port from the serial interface, synchronous to clk
`timescale 1ns/10ps
`include "dlsc_defs.vh"

module dlsc_regs (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_q,
  input  wire       dark_level_active,
  input  wire       dim_timeout,
  input  wire       dim_request,
  output reg  [6:0] dark_backlight_code_q,
  output reg        dark_dim_active_q,
  output reg  [6:0] dark_full_current_code_q,
  output reg  [6:0] dark_dimmed_current_code_q,
  output reg  [1:0] sink_fade_law_select_q,
  output reg        sink_square_dac_q,
  output reg        sink_nonlinear_steps_q,
  output reg  [1:0] sink_cubic_profile_q,
  output reg  [6:0] sink_enable_q,
  output reg  [6:0] sink_active_q,
  output reg  [1:0] sink_on_time_q,
  output reg  [1:0] sink7_off_time_q,
  output reg  [1:0] sink6_off_time_q,
  output reg  [1:0] sink5_off_time_q
);

  // ********************************
  // register writes
  // ********************************
  reg [6:0]  sink_start_q;
  reg [23:0] tick_cnt_q;
  reg        tick_q;
  wire [6:0] blink_on;
  wire [1:0] off_sel [0:6];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dark_full_current_code_q   <= 7'h00;
      dark_dimmed_current_code_q <= 7'h00;
      sink_fade_law_select_q     <= 2'h0;
      sink_enable_q              <= 7'h00;
      sink_on_time_q             <= 2'h0;
      sink7_off_time_q           <= 2'h0;
      sink6_off_time_q           <= 2'h0;
      sink5_off_time_q           <= 2'h0;
      sink_start_q               <= 7'h00;
    end else begin
      sink_start_q <= 7'h00;
      if (reg_wr) begin
        case (reg_addr)
          `DLSC_ADDR_DARK_MAX: begin
            dark_full_current_code_q <= reg_wdata[`DLSC_CODE_MSB:0];
          end
          `DLSC_ADDR_DARK_DIM: begin
            dark_dimmed_current_code_q <= reg_wdata[`DLSC_CODE_MSB:0];
          end
          `DLSC_ADDR_FADE_LAW: begin
            sink_fade_law_select_q <= reg_wdata[`DLSC_LAW_MSB:0];
          end
          `DLSC_ADDR_SINK_EN: begin
            sink_enable_q <= reg_wdata[6:0];
            // newly enabled sinks in one write start in step
            sink_start_q  <= reg_wdata[6:0] & ~sink_enable_q;
          end
          `DLSC_ADDR_SINK_TIME1: begin
            sink_on_time_q   <= reg_wdata[7:6];
            sink7_off_time_q <= reg_wdata[5:4];
            sink6_off_time_q <= reg_wdata[3:2];
            sink5_off_time_q <= reg_wdata[1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ********************************
  // read back
  // ********************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= `DLSC_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `DLSC_ADDR_DARK_MAX:   reg_rdata_q <= {1'b0, dark_full_current_code_q};
        `DLSC_ADDR_DARK_DIM:   reg_rdata_q <= {1'b0, dark_dimmed_current_code_q};
        `DLSC_ADDR_FADE_LAW:   reg_rdata_q <= {6'h00, sink_fade_law_select_q};
        `DLSC_ADDR_SINK_EN:    reg_rdata_q <= {1'b0, sink_enable_q};
        `DLSC_ADDR_SINK_TIME1: reg_rdata_q <= {sink_on_time_q, sink7_off_time_q, sink6_off_time_q, sink5_off_time_q};
        default:               reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ********************************
  // dark backlight dim selection
  // ********************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dark_dim_active_q     <= 1'b0;
      dark_backlight_code_q <= 7'h00;
    end else begin
      if (!dark_level_active) begin
        dark_dim_active_q <= 1'b0;
      end else if (dim_timeout || dim_request) begin
        dark_dim_active_q <= 1'b1;
      end
      if (dark_level_active && (dim_timeout || dim_request || dark_dim_active_q)) begin
        dark_backlight_code_q <= dark_dimmed_current_code_q;
      end else begin
        dark_backlight_code_q <= dark_full_current_code_q;
      end
    end
  end

  // ********************************
  // fade law decode
  // ********************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sink_square_dac_q      <= 1'b0;
      sink_nonlinear_steps_q <= 1'b0;
      sink_cubic_profile_q   <= 2'h0;
    end else begin
      case (sink_fade_law_select_q)
        `DLSC_LAW_LIN: begin
          sink_square_dac_q      <= 1'b0;
          sink_nonlinear_steps_q <= 1'b0;
          sink_cubic_profile_q   <= 2'h0;
        end
        `DLSC_LAW_SQR: begin
          sink_square_dac_q      <= 1'b1;
          sink_nonlinear_steps_q <= 1'b0;
          sink_cubic_profile_q   <= 2'h0;
        end
        `DLSC_LAW_CUBIC_A: begin
          sink_square_dac_q      <= 1'b1;
          sink_nonlinear_steps_q <= 1'b1;
          sink_cubic_profile_q   <= 2'h1;
        end
        default: begin
          sink_square_dac_q      <= 1'b1;
          sink_nonlinear_steps_q <= 1'b1;
          sink_cubic_profile_q   <= 2'h2;
        end
      endcase
    end
  end

  // ********************************
  // blink timebase and sequencers
  // ********************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 24'h000000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == `DLSC_TICK_LAST) begin
      tick_cnt_q <= 24'h000000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
      tick_q     <= 1'b0;
    end
  end

  // sinks 1 to 4 have their off times elsewhere; held at disabled here
  assign off_sel[0] = 2'h0;
  assign off_sel[1] = 2'h0;
  assign off_sel[2] = 2'h0;
  assign off_sel[3] = 2'h0;
  assign off_sel[4] = sink5_off_time_q;
  assign off_sel[5] = sink6_off_time_q;
  assign off_sel[6] = sink7_off_time_q;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_sink
      dlsc_blink u_blink (
        .clk       (clk),
        .rst_n     (rst_n),
        .tick      (tick_q),
        .start     (sink_start_q[gi]),
        .enable    (sink_enable_q[gi]),
        .on_sel    (sink_on_time_q),
        .off_sel   (off_sel[gi]),
        .sink_on_q (blink_on[gi])
      );
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sink_active_q <= 7'h00;
    end else begin
      sink_active_q <= blink_on;
    end
  end

endmodule

/* tb/dlsc_regs_sva.sv */
// checker for the dark-level and sink register slice
// assumes binding to dlsc_regs, single clock domain
`timescale 1ns/10ps
// ****************
// register checks
// ****************
module dlsc_regs_sva (
  input wire       clk,
  input wire       rst_n,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire       dark_level_active,
  input wire       dim_request,
  input wire [6:0] dark_backlight_code_q,
  input wire [6:0] dark_full_current_code_q,
  input wire [6:0] dark_dimmed_current_code_q,
  input wire [1:0] sink_fade_law_select_q,
  input wire       sink_square_dac_q,
  input wire       sink_nonlinear_steps_q,
  input wire [1:0] sink_cubic_profile_q,
  input wire [6:0] sink_enable_q,
  input wire [6:0] sink_active_q,
  input wire       dim_timeout,
  input wire       dark_dim_active_q,
  input wire [1:0] sink_on_time_q,
  input wire [1:0] sink7_off_time_q,
  input wire [1:0] sink6_off_time_q,
  input wire [1:0] sink5_off_time_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(a); reg_wr && reg_addr == a; endsequence
  sequence s_en; s_wr(8'h10) ##1 (!reg_wr)[*2]; endsequence
  sequence s_dim; (dark_level_active && dim_request && !reg_wr)[*3]; endsequence
  property p_max; s_wr(8'h0d) |=> dark_full_current_code_q == $past(reg_wdata[6:0]); endproperty
  property p_dimw; s_wr(8'h0e) |=> dark_dimmed_current_code_q == $past(reg_wdata[6:0]); endproperty
  property p_law; s_wr(8'h0f) |=> sink_fade_law_select_q == $past(reg_wdata[1:0]); endproperty
  property p_enw; s_wr(8'h10) |=> sink_enable_q == $past(reg_wdata[6:0]); endproperty
  property p_sqr; 1'b1 |-> sink_square_dac_q == ($past(sink_fade_law_select_q) != 2'h0); endproperty
  property p_cub; 1'b1 |-> {sink_nonlinear_steps_q, sink_cubic_profile_q}
    == {$past(sink_fade_law_select_q[1]), $past(sink_fade_law_select_q) == 2'h3,
        $past(sink_fade_law_select_q) == 2'h2}; endproperty
  property p_rd; reg_rd && !reg_wr && reg_addr == 8'h10 |=> reg_rdata_q == {1'b0, $past(sink_enable_q)}; endproperty
  property p_on; s_en |=> (sink_active_q[3:0] & $past(reg_wdata[3:0], 3)) == $past(reg_wdata[3:0], 3); endproperty
  property p_dim; s_dim |-> dark_backlight_code_q == dark_dimmed_current_code_q; endproperty
  property p_time; s_wr(8'h11) |=> {sink_on_time_q, sink7_off_time_q, sink6_off_time_q, sink5_off_time_q}
    == $past(reg_wdata); endproperty
  property p_hold; 1'b1 |-> sink_active_q[3:0] == $past(sink_enable_q[3:0], 2); endproperty
  property p_clr; !dark_level_active |=> !dark_dim_active_q; endproperty
  property p_set; dark_level_active && (dim_timeout || dim_request) |=> dark_dim_active_q; endproperty
  a_max: assert property (p_max) else $error("full code not stored");
  a_dimw: assert property (p_dimw) else $error("dim code not stored");
  a_law: assert property (p_law) else $error("law not stored");
  a_enw: assert property (p_enw) else $error("enables not stored");
  a_sqr: assert property (p_sqr) else $error("square dac select wrong");
  a_cub: assert property (p_cub) else $error("step profile wrong");
  a_rd: assert property (p_rd) else $error("enable readback wrong");
  a_on: assert property (p_on) else $error("enabled sink not on");
  a_dim: assert property (p_dim) else $error("dim code not applied");
  a_time: assert property (p_time) else $error("timing fields not stored");
  a_hold: assert property (p_hold) else $error("sink without off time not following enable");
  a_clr: assert property (p_clr) else $error("dim latch not cleared");
  a_set: assert property (p_set) else $error("dim latch not set");
endmodule
bind dlsc_regs dlsc_regs_sva chk_u (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q,
  .dark_level_active, .dim_request, .dark_backlight_code_q, .dark_full_current_code_q,
  .dark_dimmed_current_code_q, .sink_fade_law_select_q, .sink_square_dac_q, .sink_nonlinear_steps_q,
  .sink_cubic_profile_q, .sink_enable_q, .sink_active_q, .dim_timeout, .dark_dim_active_q,
  .sink_on_time_q, .sink7_off_time_q, .sink6_off_time_q, .sink5_off_time_q);

/* tb/dlsc_host_model.sv */
// host model: byte register writes and reads
// assumes the designer's one-cycle strobe port
`timescale 1ns/10ps
module dlsc_host_model (
  input  wire       clk,
  input  wire [7:0] reg_rdata_q,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // released lines show the inverse, not the last value
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk);
      d = reg_rdata_q;
    end
  endtask
endmodule

/* tb/dlsc_regs_tb_top.sv */
// testbench for the dark-level and sink register slice
// assumes the host model drives the register port
`timescale 1ns/10ps
module dlsc_regs_tb_top;
  localparam [47:0] ADDRS = 48'h0d0e0f101112;
  localparam [47:0] MASKS = 48'h7f7f037fff00;
  reg        clk    = 1'b0;
  reg        rst_n  = 1'b0;
  reg        dark   = 1'b0;
  reg        dim_to = 1'b0;
  reg        dim_rq = 1'b0;
  integer    failures = 0;
  integer    compares = 0;
  wire       wr, rd, sq, nl, dim_act;
  wire [7:0] addr, wdata, rdata;
  wire [6:0] bl_code, act;
  wire [1:0] prof;
  always #20 clk = ~clk;
  dlsc_host_model host_u (.clk(clk), .reg_rdata_q(rdata), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata));
  dlsc_regs dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata_q(rdata), .dark_level_active(dark), .dim_timeout(dim_to), .dim_request(dim_rq),
    .dark_backlight_code_q(bl_code), .dark_dim_active_q(dim_act), .dark_full_current_code_q(),
    .dark_dimmed_current_code_q(), .sink_fade_law_select_q(), .sink_square_dac_q(sq),
    .sink_nonlinear_steps_q(nl), .sink_cubic_profile_q(prof), .sink_enable_q(), .sink_active_q(act),
    .sink_on_time_q(), .sink7_off_time_q(), .sink6_off_time_q(), .sink5_off_time_q());
  // ****************
  // shared tasks
  // ****************
  task check(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task summarize;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task t_regs;
    reg [7:0] d;
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        host_u.rd(ADDRS[47-8*i -: 8], d);
        check(d, 8'h00);
        host_u.wr(ADDRS[47-8*i -: 8], 8'hff);
        host_u.rd(ADDRS[47-8*i -: 8], d);
        check(d, MASKS[47-8*i -: 8]);
      end
      $display("t_regs done");
    end
  endtask
  task t_law;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        host_u.wr(8'h0f, 8'hfc | i[7:0]);
        cyc(2);
        check({4'h0, sq, nl, prof}, {4'h0, i != 0, i > 1, i == 3, i == 2});
      end
      $display("t_law done");
    end
  endtask
  task t_sink;
    begin
      host_u.wr(8'h11, 8'h00);
      host_u.wr(8'h10, 8'hff);
      cyc(4);
      check({1'b0, act}, 8'h7f);
      host_u.wr(8'h10, 8'h2a);
      cyc(4);
      check({1'b0, act}, 8'h2a);
      host_u.wr(8'h10, 8'h00);
      // blinking sinks 5 to 7: longest on time, shortest off time
      host_u.wr(8'h11, 8'hd5);
      cyc(2);
      check({1'b0, act}, 8'h00);
      // all three enabled in one write so they start in step
      host_u.wr(8'h10, 8'h70);
      cyc(4);
      check({1'b0, act}, 8'h70);
      cyc(200);
      check({1'b0, act}, 8'h70);
      $display("t_sink done");
    end
  endtask
  task t_dim;
    begin
      host_u.wr(8'h0d, 8'h7f);
      host_u.wr(8'h0e, 8'h81);
      @(posedge clk) dark <= 1'b1;
      cyc(3);
      check({1'b0, bl_code}, 8'h7f);
      @(posedge clk) dim_to <= 1'b1;
      @(posedge clk) dim_to <= 1'b0;
      cyc(3);
      check({1'b0, bl_code}, 8'h01);
      check({7'h00, dim_act}, 8'h01);
      @(posedge clk) dark <= 1'b0;
      @(posedge clk) dark <= 1'b1;
      cyc(3);
      check({1'b0, bl_code}, 8'h7f);
      check({7'h00, dim_act}, 8'h00);
      @(posedge clk) dim_rq <= 1'b1;
      cyc(3);
      check({1'b0, bl_code}, 8'h01);
      $display("t_dim done");
    end
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_law;
    t_sink;
    t_dim;
    summarize;
  end
  initial begin
    #400000;
    failures = failures + 1;
    summarize;
  end
endmodule
